// ===== design/cmplut_top.sv
// Overview of operation
// - Four separately programmed lookup tables.
// - Two comparator-selected inputs, one output each.
// - Outputs feed the digital routing interface.
// - Stored four-bit word selects the function.
// - Constants, pass and invert single input.
// - AND, masked AND, NOR, NAND codes.
// - XOR, OR, XNOR, masked OR codes.
module cmplut_top
  import cmplut_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [cmplut_pkg::NUM_CMP-1:0] cmp_in,
  input wire logic cfg_wr,
  input wire cmplut_pkg::cmplut_idx_t cfg_idx,
  input wire cmplut_pkg::cmplut_word_t cfg_word,
  input wire cmplut_pkg::cmplut_sel_t cfg_sel_a,
  input wire cmplut_pkg::cmplut_sel_t cfg_sel_b,
  input wire cmplut_pkg::cmplut_dest_t cfg_dest,
  input wire cmplut_pkg::cmplut_idx_t rd_idx,
  output cmplut_pkg::cmplut_word_t rd_word,
  output cmplut_pkg::cmplut_sel_t rd_sel_a,
  output cmplut_pkg::cmplut_sel_t rd_sel_b,
  output cmplut_pkg::cmplut_dest_t rd_dest,
  output logic [cmplut_pkg::NUM_LUT-1:0] lut_out,
  output logic [cmplut_pkg::NUM_LUT-1:0] route_logic,
  output logic [cmplut_pkg::NUM_LUT-1:0] route_dma,
  output logic [cmplut_pkg::NUM_LUT-1:0] route_io,
  output logic [cmplut_pkg::NUM_LUT-1:0] route_irq
);

  // Per-instance configuration
  cmplut_word_t word_q [NUM_LUT];
  cmplut_word_t word_d [NUM_LUT];
  cmplut_sel_t sel_a_q [NUM_LUT];
  cmplut_sel_t sel_a_d [NUM_LUT];
  cmplut_sel_t sel_b_q [NUM_LUT];
  cmplut_sel_t sel_b_d [NUM_LUT];
  cmplut_dest_t dest_q [NUM_LUT];
  cmplut_dest_t dest_d [NUM_LUT];
  logic [NUM_LUT-1:0] hit;

  // Readback
  cmplut_word_t rd_word_q;
  cmplut_word_t rd_word_d;
  cmplut_sel_t rd_sel_a_q;
  cmplut_sel_t rd_sel_a_d;
  cmplut_sel_t rd_sel_b_q;
  cmplut_sel_t rd_sel_b_d;
  cmplut_dest_t rd_dest_q;
  cmplut_dest_t rd_dest_d;

  // Function results and routed copies
  logic [NUM_LUT-1:0] cell_y;
  logic [NUM_LUT-1:0] in_a;
  logic [NUM_LUT-1:0] in_b;
  logic [NUM_LUT-1:0] out_q;
  logic [NUM_LUT-1:0] out_d;
  logic [NUM_LUT-1:0] r_logic_q;
  logic [NUM_LUT-1:0] r_logic_d;
  logic [NUM_LUT-1:0] r_dma_q;
  logic [NUM_LUT-1:0] r_dma_d;
  logic [NUM_LUT-1:0] r_io_q;
  logic [NUM_LUT-1:0] r_io_d;
  logic [NUM_LUT-1:0] r_irq_q;
  logic [NUM_LUT-1:0] r_irq_d;

  // True when the current write addresses instance i
  function automatic logic cfg_hit(input logic wr, input cmplut_idx_t idx, input int i);
    return wr && (idx == IDX_W'(i));
  endfunction

  // Write decode, shared by both setup groups
  always_comb begin
    for (int i = 0; i < NUM_LUT; i++) begin
      hit[i] = cfg_hit(cfg_wr, cfg_idx, i);
    end
  end

  // Function words: one instance per write, others untouched
  always_comb begin
    for (int i = 0; i < NUM_LUT; i++) begin
      word_d[i] = word_q[i];
      if (hit[i]) begin
        word_d[i] = cfg_word;
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_LUT; i++) begin
      if (reset) begin
        word_q[i] <= CW_RESET;
      end else begin
        word_q[i] <= word_d[i];
      end
    end
  end

  // Input selects and route enables, written together with the word
  always_comb begin
    for (int i = 0; i < NUM_LUT; i++) begin
      sel_a_d[i] = sel_a_q[i];
      sel_b_d[i] = sel_b_q[i];
      dest_d[i] = dest_q[i];
      if (hit[i]) begin
        sel_a_d[i] = cfg_sel_a;
        sel_b_d[i] = cfg_sel_b;
        dest_d[i] = cfg_dest;
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_LUT; i++) begin
      if (reset) begin
        sel_a_q[i] <= SEL_RESET;
        sel_b_q[i] <= SEL_RESET;
        dest_q[i] <= DEST_RESET;
      end else begin
        sel_a_q[i] <= sel_a_d[i];
        sel_b_q[i] <= sel_b_d[i];
        dest_q[i] <= dest_d[i];
      end
    end
  end

  // Input selection; both inputs may pick the same comparator
  always_comb begin
    for (int i = 0; i < NUM_LUT; i++) begin
      in_a[i] = cmplut_pick(cmp_in, sel_a_q[i]);
      in_b[i] = cmplut_pick(cmp_in, sel_b_q[i]);
    end
  end

  // One cell per instance, each on its own stored word
  for (genvar g = 0; g < NUM_LUT; g++) begin : g_cell
    cmplut_cell cmplut_cell_inst (
      .word(word_q[g]),
      .a(in_a[g]),
      .b(in_b[g]),
      .y(cell_y[g])
    );
  end

  // Gate one result onto one destination enable
  function automatic logic route_gate(input logic y, input cmplut_dest_t dest, input int pos);
    return y & dest[pos];
  endfunction

  // Outputs are flopped once so the routing fabric sees glitch-free levels;
  // the cost is one cycle of latency from comparator to route.
  always_comb begin
    out_d = cell_y;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      out_q <= OUT_RESET;
    end else begin
      out_q <= out_d;
    end
  end

  // A route whose enable is clear holds low, whatever the function gives
  always_comb begin
    for (int i = 0; i < NUM_LUT; i++) begin
      r_logic_d[i] = route_gate(cell_y[i], dest_q[i], DEST_LOGIC);
      r_dma_d[i] = route_gate(cell_y[i], dest_q[i], DEST_DMA);
      r_io_d[i] = route_gate(cell_y[i], dest_q[i], DEST_IO);
      r_irq_d[i] = route_gate(cell_y[i], dest_q[i], DEST_IRQ);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r_logic_q <= OUT_RESET;
      r_dma_q <= OUT_RESET;
      r_io_q <= OUT_RESET;
      r_irq_q <= OUT_RESET;
    end else begin
      r_logic_q <= r_logic_d;
      r_dma_q <= r_dma_d;
      r_io_q <= r_io_d;
      r_irq_q <= r_irq_d;
    end
  end

  // Readback of stored setup, one cycle after the index is presented
  always_comb begin
    rd_word_d = word_q[rd_idx];
    rd_sel_a_d = sel_a_q[rd_idx];
    rd_sel_b_d = sel_b_q[rd_idx];
    rd_dest_d = dest_q[rd_idx];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_word_q <= CW_RESET;
      rd_sel_a_q <= SEL_RESET;
      rd_sel_b_q <= SEL_RESET;
      rd_dest_q <= DEST_RESET;
    end else begin
      rd_word_q <= rd_word_d;
      rd_sel_a_q <= rd_sel_a_d;
      rd_sel_b_q <= rd_sel_b_d;
      rd_dest_q <= rd_dest_d;
    end
  end

  // Every output is a flop; nothing combinational reaches a pin
  assign rd_word = rd_word_q;
  assign rd_sel_a = rd_sel_a_q;
  assign rd_sel_b = rd_sel_b_q;
  assign rd_dest = rd_dest_q;
  assign lut_out = out_q;
  assign route_logic = r_logic_q;
  assign route_dma = r_dma_q;
  assign route_io = r_io_q;
  assign route_irq = r_irq_q;

endmodule // cmplut_top

// ===== design/cmplut_pkg.sv
package cmplut_pkg;

  // Instance and width figures
  localparam int NUM_LUT = 4;
  localparam int NUM_CMP = 4;
  localparam int CW_W = 4;
  localparam int IDX_W = 2;
  localparam int SEL_W = 2;
  localparam int NUM_DEST = 4;

  typedef logic [CW_W-1:0] cmplut_word_t;
  typedef logic [IDX_W-1:0] cmplut_idx_t;
  typedef logic [SEL_W-1:0] cmplut_sel_t;
  typedef logic [NUM_DEST-1:0] cmplut_dest_t;

  // Values after reset
  localparam cmplut_word_t CW_RESET = 4'h0;
  localparam cmplut_sel_t SEL_RESET = 2'h0;
  localparam cmplut_dest_t DEST_RESET = 4'h0;
  localparam logic [NUM_LUT-1:0] OUT_RESET = 4'h0;

  // Bit positions of the routing destination enables
  localparam int DEST_LOGIC = 0;
  localparam int DEST_DMA = 1;
  localparam int DEST_IO = 2;
  localparam int DEST_IRQ = 3;

  // Function codes
  localparam cmplut_word_t FN_ZERO = 4'h0;
  localparam cmplut_word_t FN_AND = 4'h1;
  localparam cmplut_word_t FN_A_ANDN_B = 4'h2;
  localparam cmplut_word_t FN_A = 4'h3;
  localparam cmplut_word_t FN_NA_AND_B = 4'h4;
  localparam cmplut_word_t FN_B = 4'h5;
  localparam cmplut_word_t FN_XOR = 4'h6;
  localparam cmplut_word_t FN_OR = 4'h7;
  localparam cmplut_word_t FN_NOR = 4'h8;
  localparam cmplut_word_t FN_XNOR = 4'h9;
  localparam cmplut_word_t FN_NOT_B = 4'ha;
  localparam cmplut_word_t FN_A_ORN_B = 4'hb;
  localparam cmplut_word_t FN_NOT_A = 4'hc;
  localparam cmplut_word_t FN_NA_OR_B = 4'hd;
  localparam cmplut_word_t FN_NAND = 4'he;
  localparam cmplut_word_t FN_ONE = 4'hf;

  function automatic logic cmplut_eval(input cmplut_word_t word, input logic a, input logic b);
    logic y;
    y = 1'b0;
    unique case (word)
      FN_ZERO: y = 1'b0;
      FN_AND: y = a & b;
      FN_A_ANDN_B: y = a & ~b;
      FN_A: y = a;
      FN_NA_AND_B: y = ~a & b;
      FN_B: y = b;
      FN_XOR: y = a ^ b;
      FN_OR: y = a | b;
      FN_NOR: y = ~(a | b);
      FN_XNOR: y = ~(a ^ b);
      FN_NOT_B: y = ~b;
      FN_A_ORN_B: y = a | ~b;
      FN_NOT_A: y = ~a;
      FN_NA_OR_B: y = ~a | b;
      FN_NAND: y = ~(a & b);
      FN_ONE: y = 1'b1;
    endcase
    return y;
  endfunction

  function automatic logic cmplut_pick(input logic [NUM_CMP-1:0] cmp, input cmplut_sel_t sel);
    return cmp[sel];
  endfunction

endpackage

// ===== design/cmplut_cell.sv
module cmplut_cell
  import cmplut_pkg::*;
(
  input wire cmplut_pkg::cmplut_word_t word,
  input wire logic a,
  input wire logic b,
  output logic y
);

  always_comb begin
    y = cmplut_eval(word, a, b);
  end

endmodule // cmplut_cell

// ===== test/cmplut_cmp_model.sv
// Comparator bank; levels settle one edge after the bench asks
module cmplut_cmp_model (
  input wire logic clk,
  input wire logic [3:0] level,
  output logic [3:0] cmp_out
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk) begin
    cmp_out <= level;
  end
endmodule // cmplut_cmp_model

// ===== test/cmplut_monitor.sv
module cmplut_monitor
  import cmplut_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] cmp_in,
  input wire logic cfg_wr,
  input wire cmplut_idx_t cfg_idx,
  input wire cmplut_word_t cfg_word,
  input wire cmplut_sel_t cfg_sel_a,
  input wire cmplut_sel_t cfg_sel_b,
  input wire cmplut_dest_t cfg_dest,
  input wire cmplut_idx_t rd_idx,
  input wire cmplut_word_t rd_word,
  input wire logic [3:0] lut_out,
  input wire logic [3:0] route_logic,
  input wire logic [3:0] route_dma,
  input wire logic [3:0] route_io,
  input wire logic [3:0] route_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Shadow setup: dest, sel_a, sel_b, word
  logic [11:0] cfg_q [4];
  logic [11:0] cfg_d [4];
  logic [3:0] y;
  logic [3:0] r [4];
  always_comb begin
    cfg_d = cfg_q;
    if (cfg_wr) cfg_d[cfg_idx] = {cfg_dest, cfg_sel_a, cfg_sel_b, cfg_word};
    for (int i = 0; i < 4; i++) begin
      y[i] = cfg_q[i][{~cmp_in[cfg_q[i][7:6]], ~cmp_in[cfg_q[i][5:4]]}];
      for (int k = 0; k < 4; k++) r[k][i] = y[i] & cfg_q[i][8+k];
    end
  end
  always_ff @(posedge clk) begin
    if (reset) cfg_q <= '{default: 12'h000};
    else cfg_q <= cfg_d;
  end
  a_lut_func: assert property (lut_out == $past(y))
    else $error("lut output wrong");
  a_route_logic: assert property (route_logic == $past(r[0]))
    else $error("logic route wrong");
  a_route_dma: assert property (route_dma == $past(r[1]))
    else $error("dma route wrong");
  a_route_io: assert property (route_io == $past(r[2]))
    else $error("io route wrong");
  a_route_irq: assert property (route_irq == $past(r[3]))
    else $error("irq route wrong");
  a_rd_word: assert property (rd_word == $past(cfg_q[rd_idx][3:0]))
    else $error("readback word wrong");
  a_reset_zero: assert property (disable iff (1'b0) reset |=> lut_out == 4'h0 && rd_word == 4'h0)
    else $error("not cleared by reset");
  a_steady_out: assert property ((!cfg_wr && $stable(cmp_in))[*2] |=> $stable(lut_out))
    else $error("output moved without cause");
  c_write: cover property (cfg_wr);
  c_shared_cmp: cover property (cfg_wr && cfg_sel_a == cfg_sel_b);
  c_irq: cover property (route_irq != 4'h0);
  c_all_one: cover property (lut_out == 4'hf);
endmodule // cmplut_monitor
bind cmplut_top cmplut_monitor cmplut_monitor_inst (.clk, .reset, .cmp_in, .cfg_wr, .cfg_idx,
  .cfg_word, .cfg_sel_a, .cfg_sel_b, .cfg_dest, .rd_idx, .rd_word, .lut_out, .route_logic,
  .route_dma, .route_io, .route_irq);

// ===== test/cmplut_top_tb.sv
module cmplut_top_tb;
  import cmplut_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset = 1'b1, cfg_wr = 1'b0;
  logic [3:0] lvl = 4'h0, cmp_in, lut_out, rl, rdm, rio, rirq;
  cmplut_idx_t cfg_idx = 2'h0, rd_idx = 2'h0;
  cmplut_word_t cfg_word = 4'h0, rd_word;
  cmplut_sel_t cfg_sel_a = 2'h0, cfg_sel_b = 2'h0, rsa, rsb;
  cmplut_dest_t cfg_dest = 4'h0, rd_dest;
  int failures = 0, n_compared = 0;
  cmplut_cmp_model cmplut_cmp_model_inst (.clk(clk), .level(lvl), .cmp_out(cmp_in));
  cmplut_top cmplut_top_inst (.clk(clk), .reset(reset), .cmp_in(cmp_in), .cfg_wr(cfg_wr),
    .cfg_idx(cfg_idx), .cfg_word(cfg_word), .cfg_sel_a(cfg_sel_a), .cfg_sel_b(cfg_sel_b),
    .cfg_dest(cfg_dest), .rd_idx(rd_idx), .rd_word(rd_word), .rd_sel_a(rsa), .rd_sel_b(rsb),
    .rd_dest(rd_dest), .lut_out(lut_out), .route_logic(rl), .route_dma(rdm), .route_io(rio),
    .route_irq(rirq));
  initial forever #5 clk = ~clk;
  task automatic chk(string s, logic [3:0] e, logic [3:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(cmplut_idx_t i, cmplut_word_t w, cmplut_sel_t sa, cmplut_sel_t sb,
    cmplut_dest_t d);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_idx <= i;
    cfg_word <= w;
    cfg_sel_a <= sa;
    cfg_sel_b <= sb;
    cfg_dest <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask
  // Model flop plus output flop, then settle
  task automatic drive(logic [3:0] v);
    @(posedge clk);
    lvl <= v;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    lvl <= 4'hf;
    reset <= 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    drive(4'hf);
    chk("lut_out", 4'h0, lut_out);
    chk("route_irq", 4'h0, rirq);
    chk("rd_word", 4'h0, rd_word);
    chk("rd_dest", 4'h0, rd_dest);
    $display("test reset done");
  endtask
  // A on comparator 3, B on 1; decoys on 2 and 0 hold the opposite
  task automatic t_codes();
    logic a, b;
    cmplut_word_t code;
    @(posedge clk);
    rd_idx <= 2'h2;
    for (int w = 0; w < 16; w++) begin
      code = 4'(w);
      wr(2'h2, code, 2'h3, 2'h1, 4'hf);
      for (int ab = 0; ab < 4; ab++) begin
        {a, b} = 2'(ab);
        drive({a, ~b, b, ~a});
        chk("lut_out", {1'b0, code[{~a, ~b}], 2'b00}, lut_out);
        chk("rd_word", code, rd_word);
      end
    end
    chk("rd_sel", 4'hd, {rsa, rsb});
    chk("rd_dest", 4'hf, rd_dest);
    $display("test codes done");
  endtask
  // Writes one after another, one route each
  task automatic t_route();
    for (int i = 0; i < 4; i++) wr(2'(i), FN_ONE, 2'h3, 2'h1, 4'h1 << i);
    drive(4'h0);
    chk("lut_out", 4'hf, lut_out);
    chk("route_logic", 4'h1, rl);
    chk("route_dma", 4'h2, rdm);
    chk("route_io", 4'h4, rio);
    chk("route_irq", 4'h8, rirq);
    $display("test route done");
  endtask
  // Both inputs on comparator 0, then A on 0 and B on 2
  task automatic t_sel();
    @(posedge clk);
    rd_idx <= 2'h1;
    wr(2'h1, FN_XOR, 2'h0, 2'h0, 4'h0);
    drive(4'h1);
    chk("lut_out", 4'hd, lut_out);
    chk("route_dma", 4'h0, rdm);
    wr(2'h1, FN_A_ANDN_B, 2'h0, 2'h2, 4'h2);
    drive(4'h1);
    chk("lut_out", 4'hf, lut_out);
    chk("route_dma", 4'h2, rdm);
    drive(4'h5);
    chk("lut_out", 4'hd, lut_out);
    chk("rd_sel", 4'h2, {rsa, rsb});
    chk("rd_dest", 4'h2, rd_dest);
    $display("test sel done");
  endtask
  task automatic close_out();
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    close_out();
  end
  initial begin
    t_reset();
    t_codes();
    t_route();
    t_sel();
    @(posedge clk);
    t_reset();
    close_out();
  end
endmodule // cmplut_top_tb
